// ---- rtl/output_condition_detector.v ----
// multi-function output condition detector: two relays and one photo-coupler
// Function
// - code 51: off above level2+width2, on below level5
// - code 52: on above level3+width3, off below level6
// - code 53: inverse of code 52
// - code 39: on while accelerating above level1+width1
// - crane output off while decelerating below level4
// - frequency output: closed while the drive produces output frequency
// - code 13: active when current exceeds current agree level 0.1..999.9 A
// - current agree activation delayed by 0.1..10.0 s setting
// - current at or below level2 releases current agree after fixed 100 ms
// - current agree level2 clamped to not exceed level1
// - code 57: on after current stays at/below low level past delay
// - low-current detection disabled when its level is 0.0 A
// - low-current output releases after fixed 100 ms
// - code 14: on when frequency reaches release level while accelerating
// - brake output off when frequency reaches set level while decelerating
// - polarity bit0 relay one, bit1 relay two; 1 means normally closed
// - each of three outputs selects any function by its own code
// - frequency levels 0.0..599.0 Hz, widths 0.1..25.5 Hz
`timescale 1ns/1ps
`include "ocd_consts.vh"
module output_condition_detector #(
  parameter CLK_HZ = 10000000
) (
  input  wire                 clk,
  input  wire                 rstn,
  input  wire [`FREQ_W-1:0]   out_freq,
  input  wire [`CUR_W-1:0]    out_cur,
  input  wire                 accel,
  input  wire                 decel,
  input  wire                 freq_active,
  input  wire [`FC_WIDTH-1:0] fsel_relay_one,
  input  wire [`FC_WIDTH-1:0] fsel_relay_two,
  input  wire [`FC_WIDTH-1:0] fsel_photo,
  input  wire [1:0]           relay_polarity,
  input  wire                 photo_polarity,
  input  wire [`FREQ_W-1:0]   det_level1,
  input  wire [`FREQ_W-1:0]   det_width1,
  input  wire [`FREQ_W-1:0]   det_level2,
  input  wire [`FREQ_W-1:0]   det_width2,
  input  wire [`FREQ_W-1:0]   det_level3,
  input  wire [`FREQ_W-1:0]   det_width3,
  input  wire [`FREQ_W-1:0]   det_level4,
  input  wire [`FREQ_W-1:0]   det_level5,
  input  wire [`FREQ_W-1:0]   det_level6,
  input  wire [`CUR_W-1:0]    cur_agree_level,
  input  wire [`CUR_W-1:0]    cur_agree_level2,
  input  wire [`DLY_W-1:0]    cur_agree_delay,
  input  wire [`CUR_W-1:0]    low_cur_level,
  input  wire [`DLY_W-1:0]    low_cur_delay,
  input  wire [`FREQ_W-1:0]   brake_release_level,
  input  wire [`FREQ_W-1:0]   brake_set_level,
  output reg                  relay_one,
  output reg                  relay_two,
  output reg                  photo_out
);

  // ----------------------------------------------------------------
  // setting limits
  // ----------------------------------------------------------------
  // out-of-range settings are clamped rather than trusted
  function [`FREQ_W-1:0] clamp_f;
    input [`FREQ_W-1:0] v;
    input [`FREQ_W-1:0] lo;
    input [`FREQ_W-1:0] hi;
    begin
      if (v < lo)
        clamp_f = lo;
      else if (v > hi)
        clamp_f = hi;
      else
        clamp_f = v;
    end
  endfunction

  function [`CUR_W-1:0] clamp_c;
    input [`CUR_W-1:0] v;
    input [`CUR_W-1:0] lo;
    input [`CUR_W-1:0] hi;
    begin
      if (v < lo)
        clamp_c = lo;
      else if (v > hi)
        clamp_c = hi;
      else
        clamp_c = v;
    end
  endfunction

  function [`DLY_W-1:0] clamp_d;
    input [`DLY_W-1:0] v;
    input [`DLY_W-1:0] lo;
    input [`DLY_W-1:0] hi;
    begin
      if (v < lo)
        clamp_d = lo;
      else if (v > hi)
        clamp_d = hi;
      else
        clamp_d = v;
    end
  endfunction

  // threshold sum kept one bit wider so it cannot wrap
  function [`FREQ_W:0] on_thr;
    input [`FREQ_W-1:0] lvl;
    input [`FREQ_W-1:0] wid;
    begin
      on_thr = {1'b0, clamp_f(lvl, {`FREQ_W{1'b0}}, `FREQ_LEVEL_MAX)}
             + {1'b0, clamp_f(wid, `FREQ_WIDTH_MIN, `FREQ_WIDTH_MAX)};
    end
  endfunction

  function [`FREQ_W-1:0] lvl_f;
    input [`FREQ_W-1:0] lvl;
    begin
      lvl_f = clamp_f(lvl, {`FREQ_W{1'b0}}, `FREQ_LEVEL_MAX);
    end
  endfunction

  // ----------------------------------------------------------------
  // clamped thresholds
  // ----------------------------------------------------------------
  wire [`FREQ_W:0] thr1 = on_thr(det_level1, det_width1);
  wire [`FREQ_W:0] thr2 = on_thr(det_level2, det_width2);
  wire [`FREQ_W:0] thr3 = on_thr(det_level3, det_width3);
  wire [`FREQ_W-1:0] lvl4 = lvl_f(det_level4);
  wire [`FREQ_W-1:0] lvl5 = lvl_f(det_level5);
  wire [`FREQ_W-1:0] lvl6 = lvl_f(det_level6);
  wire [`FREQ_W:0] freq_x = {1'b0, out_freq};

  wire [`CUR_W-1:0] cur_lvl1 = clamp_c(cur_agree_level, `CUR_LEVEL_MIN, `CUR_LEVEL_MAX);
  wire [`CUR_W-1:0] cur_lvl2 = (cur_agree_level2 > cur_lvl1) ? cur_lvl1
                                                              : cur_agree_level2;
  wire [`CUR_W-1:0] low_lvl  = (low_cur_level > `CUR_LEVEL_MAX) ? `CUR_LEVEL_MAX
                                                               : low_cur_level;
  wire [`DLY_W-1:0] cur_dly  = clamp_d(cur_agree_delay, `CUR_DLY_MIN, `CUR_DLY_MAX);
  wire [`DLY_W-1:0] low_dly  = clamp_d(low_cur_delay, {`DLY_W{1'b0}}, `LOW_DLY_MAX);
  wire [`FREQ_W-1:0] brk_rel = lvl_f(brake_release_level);
  wire [`FREQ_W-1:0] brk_set = lvl_f(brake_set_level);

  // ----------------------------------------------------------------
  // timebase
  // ----------------------------------------------------------------
  // one shared tick keeps every delay in step; a delay may end up to one tick early
  wire tick;

  tick_divider #(
    .CLK_HZ  (CLK_HZ),
    .TICK_MS (`TICK_MS)
  ) u_tick (
    .clk  (clk),
    .rstn (rstn),
    .tick (tick)
  );

  // ----------------------------------------------------------------
  // frequency hysteresis detectors
  // ----------------------------------------------------------------
  reg fdet4_r;
  reg fdet5_r;
  reg crane_r;
  reg brake_r;
  reg fdet4_nxt;
  reg fdet5_nxt;
  reg crane_nxt;
  reg brake_nxt;

  always @* begin
    // each detector holds between its thresholds
    fdet4_nxt = fdet4_r;
    if (freq_x > thr2)
      fdet4_nxt = 1'b0;
    else if (out_freq < lvl5)
      fdet4_nxt = 1'b1;

    fdet5_nxt = fdet5_r;
    if (freq_x > thr3)
      fdet5_nxt = 1'b1;
    else if (out_freq < lvl6)
      fdet5_nxt = 1'b0;

    // crane turn-on is tested first when both ramp flags are set
    crane_nxt = crane_r;
    if (accel && freq_x > thr1)
      crane_nxt = 1'b1;
    else if (decel && out_freq < lvl4)
      crane_nxt = 1'b0;

    // reached means at or past, since the ramp steps may skip the exact value
    brake_nxt = brake_r;
    if (accel && out_freq >= brk_rel)
      brake_nxt = 1'b1;
    else if (decel && out_freq <= brk_set)
      brake_nxt = 1'b0;
    // a stopped drive always sets the brake, whatever the ramp flags say
    if (!freq_active)
      brake_nxt = 1'b0;
  end

  always @(posedge clk) begin
    if (!rstn) begin
      fdet4_r <= 1'b1;
      fdet5_r <= 1'b0;
      crane_r <= 1'b0;
      brake_r <= 1'b0;
    end else begin
      fdet4_r <= fdet4_nxt;
      fdet5_r <= fdet5_nxt;
      crane_r <= crane_nxt;
      brake_r <= brake_nxt;
    end
  end

  // ----------------------------------------------------------------
  // current agree and low current with timed on and off
  // ----------------------------------------------------------------
  reg  cur_agree_r;
  reg  low_cur_r;
  wire cur_on_done;
  wire cur_off_done;
  wire low_on_done;
  wire low_off_done;

  wire low_en = (low_lvl != `LOW_CUR_OFF);

  // a dip below the level restarts a timer: each delay counts one unbroken stretch
  delay_timer u_cur_on (
    .clk   (clk),
    .rstn  (rstn),
    .tick  (tick),
    .cond  (out_cur > cur_lvl1),
    .ticks (cur_dly),
    .done  (cur_on_done)
  );

  delay_timer u_cur_off (
    .clk   (clk),
    .rstn  (rstn),
    .tick  (tick),
    .cond  (cur_agree_r && out_cur <= cur_lvl2),
    .ticks (`REL_TICKS),
    .done  (cur_off_done)
  );

  delay_timer u_low_on (
    .clk   (clk),
    .rstn  (rstn),
    .tick  (tick),
    .cond  (low_en && out_cur <= low_lvl),
    .ticks (low_dly),
    .done  (low_on_done)
  );

  delay_timer u_low_off (
    .clk   (clk),
    .rstn  (rstn),
    .tick  (tick),
    .cond  (low_cur_r && !(low_en && out_cur <= low_lvl)),
    .ticks (`REL_TICKS),
    .done  (low_off_done)
  );

  always @(posedge clk) begin
    if (!rstn) begin
      cur_agree_r <= 1'b0;
      low_cur_r   <= 1'b0;
    end else begin
      if (cur_on_done)
        cur_agree_r <= 1'b1;
      else if (cur_off_done)
        cur_agree_r <= 1'b0;
      if (!low_en)
        low_cur_r <= 1'b0;
      else if (low_on_done)
        low_cur_r <= 1'b1;
      else if (low_off_done)
        low_cur_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // function selection and contact polarity
  // ----------------------------------------------------------------
  // unknown codes leave the contact de-energised in its logical sense
  function fsel;
    input [`FC_WIDTH-1:0] code;
    input                 f4;
    input                 f5;
    input                 cr;
    input                 br;
    input                 fa;
    input                 ca;
    input                 lc;
    begin
      case (code)
        `FC_CUR_AGREE: fsel = ca;
        `FC_BRAKE:     fsel = br;
        `FC_CRANE:     fsel = cr;
        `FC_FREQ_OUT:  fsel = fa;
        `FC_FDET4:     fsel = f4;
        `FC_FDET5:     fsel = f5;
        `FC_FDET6:     fsel = ~f5;
        `FC_LOW_CUR:   fsel = lc;
        default:       fsel = 1'b0;
      endcase
    end
  endfunction

  wire r1_fn = fsel(fsel_relay_one, fdet4_r, fdet5_r, crane_r, brake_r,
                    freq_active, cur_agree_r, low_cur_r);
  wire r2_fn = fsel(fsel_relay_two, fdet4_r, fdet5_r, crane_r, brake_r,
                    freq_active, cur_agree_r, low_cur_r);
  wire ph_fn = fsel(fsel_photo, fdet4_r, fdet5_r, crane_r, brake_r,
                    freq_active, cur_agree_r, low_cur_r);

  // ----------------------------------------------------------------
  // contact drive
  // ----------------------------------------------------------------
  // a normally closed contact is energised while its function is off
  function contact;
    input fn;
    input nc;
    begin
      contact = fn ^ nc;
    end
  endfunction

  always @(posedge clk) begin
    if (!rstn) begin
      relay_one <= 1'b0;
      relay_two <= 1'b0;
      photo_out <= 1'b0;
    end else begin
      relay_one <= contact(r1_fn, relay_polarity[`POL_RELAY_ONE]);
      relay_two <= contact(r2_fn, relay_polarity[`POL_RELAY_TWO]);
      photo_out <= contact(ph_fn, photo_polarity);
    end
  end

endmodule // output_condition_detector

// ---- rtl/ocd_consts.vh ----
// constants for the output condition detector
`ifndef OCD_CONSTS_VH
`define OCD_CONSTS_VH

// function codes
`define FC_WIDTH       6
`define FC_CUR_AGREE   6'h0d
`define FC_BRAKE       6'h0e
`define FC_CRANE       6'h27
`define FC_FREQ_OUT    6'h28
`define FC_FDET4       6'h33
`define FC_FDET5       6'h34
`define FC_FDET6       6'h35
`define FC_LOW_CUR     6'h39

// level widths: frequency in 0.01 Hz, current in 0.1 A
`define FREQ_W         16
`define CUR_W          14
`define FREQ_LEVEL_MAX 16'he9fc
`define FREQ_WIDTH_MIN 16'h000a
`define FREQ_WIDTH_MAX 16'h09f6
`define CUR_LEVEL_MIN  14'h0001
`define CUR_LEVEL_MAX  14'h270f
`define LOW_CUR_OFF    14'h0000

// delays counted in 10 ms ticks
`define TICK_MS        10
`define DLY_W          16
`define CUR_DLY_MIN    16'h000a
`define CUR_DLY_MAX    16'h03e8
`define LOW_DLY_MAX    16'hfffe
`define REL_DELAY_MS   100
`define REL_TICKS      16'h000a

// relay polarity field bits
`define POL_RELAY_ONE  0
`define POL_RELAY_TWO  1

`endif

// ---- rtl/tick_divider.v ----
// one-cycle pulse timebase from the system clock
`timescale 1ns/1ps
module tick_divider #(
  parameter CLK_HZ  = 10000000,
  parameter TICK_MS = 10
) (
  input  wire clk,
  input  wire rstn,
  output reg  tick
);
  localparam integer DIV = CLK_HZ / 1000 * TICK_MS;
  reg [31:0] cnt_r;

  always @(posedge clk) begin
    if (!rstn) begin
      cnt_r <= 32'h0;
      tick  <= 1'b0;
    end else if (cnt_r == DIV - 1) begin
      cnt_r <= 32'h0;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
      tick  <= 1'b0;
    end
  end
endmodule // tick_divider

// ---- rtl/delay_timer.v ----
// tick counter: done when the input has stood true for a set number of ticks
`timescale 1ns/1ps
`include "ocd_consts.vh"
module delay_timer (
  input  wire              clk,
  input  wire              rstn,
  input  wire              tick,
  input  wire              cond,
  input  wire [`DLY_W-1:0] ticks,
  output wire              done
);
  reg [`DLY_W-1:0] cnt_r;

  // counter restarts whenever the condition drops
  always @(posedge clk) begin
    if (!rstn || !cond)
      cnt_r <= {`DLY_W{1'b0}};
    else if (tick && cnt_r < ticks)
      cnt_r <= cnt_r + 1'b1;
  end

  assign done = cond && (cnt_r >= ticks);
endmodule // delay_timer

// ---- sim/load_model.sv ----
// contact load model: senses the three contact drives one cycle late
`timescale 1ns/1ps
module load_model (
  input  wire logic       clk,
  input  wire logic [2:0] drive,
  output logic      [2:0] closed
);
  // a coil pulls in no faster than one clock, so nothing is seen in the same cycle
  always @(posedge clk) begin
    closed <= drive;
  end
endmodule // load_model

// ---- sim/ocd_checker_sva.sv ----
// assertion checker for the output condition detector
`timescale 1ns/1ps
`include "ocd_consts.vh"
module ocd_checker (
  input wire logic                 clk,
  input wire logic                 rstn,
  input wire logic [`FREQ_W-1:0]   out_freq,
  input wire logic [`CUR_W-1:0]    out_cur,
  input wire logic                 freq_active,
  input wire logic [`FC_WIDTH-1:0] fsel_relay_one,
  input wire logic [`FC_WIDTH-1:0] fsel_relay_two,
  input wire logic [`FC_WIDTH-1:0] fsel_photo,
  input wire logic [1:0]           relay_polarity,
  input wire logic                 photo_polarity,
  input wire logic [`FREQ_W-1:0]   det_level2,
  input wire logic [`FREQ_W-1:0]   det_width2,
  input wire logic [`FREQ_W-1:0]   det_level3,
  input wire logic [`FREQ_W-1:0]   det_width3,
  input wire logic [`FREQ_W-1:0]   det_level6,
  input wire logic [`CUR_W-1:0]    cur_agree_level,
  input wire logic [`CUR_W-1:0]    cur_agree_level2,
  input wire logic [`CUR_W-1:0]    low_cur_level,
  input wire logic                 relay_one,
  input wire logic                 relay_two,
  input wire logic                 photo_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // only unclamped settings are judged, clamping is checked elsewhere
  wire        ok2 = det_width2 >= `FREQ_WIDTH_MIN && det_width2 <= `FREQ_WIDTH_MAX
                    && det_level2 <= `FREQ_LEVEL_MAX;
  wire        ok3 = det_width3 >= `FREQ_WIDTH_MIN && det_width3 <= `FREQ_WIDTH_MAX
                    && det_level3 <= `FREQ_LEVEL_MAX && det_level6 <= `FREQ_LEVEL_MAX;
  wire [16:0] t2  = det_level2 + det_width2;
  wire [16:0] t3  = det_level3 + det_width3;
  // level two as the device clamps it, judged only for an in-range level one
  wire        ok_c  = cur_agree_level >= `CUR_LEVEL_MIN && cur_agree_level <= `CUR_LEVEL_MAX;
  wire [13:0] lvl2c = (cur_agree_level2 > cur_agree_level) ? cur_agree_level : cur_agree_level2;
  a_fdet4_off: assert property (
    (fsel_relay_one == `FC_FDET4 && !relay_polarity[0] && ok2 && out_freq > t2)[*4]
    |-> !relay_one) else $error("relay one on above upper threshold");
  a_fdet5_on: assert property (
    (fsel_photo == `FC_FDET5 && !photo_polarity && ok3 && out_freq > t3)[*4]
    |-> photo_out) else $error("photo output off above upper threshold");
  a_fdet5_off: assert property (
    (fsel_photo == `FC_FDET5 && !photo_polarity && ok3 && out_freq < det_level6
    && out_freq <= t3)[*4] |-> !photo_out) else $error("photo output on below low level");
  a_fdet6_inverse: assert property (
    (fsel_photo == `FC_FDET5 && fsel_relay_two == `FC_FDET6 && !photo_polarity
    && !relay_polarity[1])[*4] |-> photo_out != relay_two) else $error("codes 52 53 agree");
  a_freq_follow: assert property (
    ($stable(freq_active) && fsel_photo == `FC_FREQ_OUT && !photo_polarity)[*4]
    |-> photo_out == freq_active) else $error("frequency output differs from run state");
  a_polarity_idle: assert property (
    (fsel_relay_two == 6'h00)[*3] |-> relay_two == $past(relay_polarity[1]))
    else $error("idle relay two not equal to polarity bit");
  a_cur_hold: assert property (
    (fsel_relay_one == `FC_CUR_AGREE && !relay_polarity[0] && ok_c && out_cur > lvl2c)[*4]
    ##0 relay_one |=> relay_one) else $error("current agree dropped above level two");
  a_low_disabled: assert property (
    (fsel_relay_two == `FC_LOW_CUR && !relay_polarity[1] && low_cur_level == `LOW_CUR_OFF)[*4]
    ##0 !relay_two |=> !relay_two) else $error("low current output rose while disabled");
endmodule // ocd_checker
bind output_condition_detector ocd_checker checker_inst (.*);

// ---- sim/testbench.sv ----
// self-checking testbench for the output condition detector
`timescale 1ns/1ps
`include "ocd_consts.vh"
module testbench;
  logic                 clk = 1'b0, rstn = 1'b0, accel = 1'b0, decel = 1'b0;
  logic                 freq_active = 1'b1, photo_polarity = 1'b0;
  logic [1:0]           relay_polarity = 2'b00;
  logic [`FC_WIDTH-1:0] fsel_relay_one = `FC_FDET4, fsel_relay_two = `FC_FDET6;
  logic [`FC_WIDTH-1:0] fsel_photo = `FC_FDET5;
  logic [`FREQ_W-1:0]   out_freq = 16'h0000, det_level1 = 16'h03e8, det_width1 = 16'h0064;
  logic [`FREQ_W-1:0]   det_level2 = 16'h03e8, det_width2 = 16'h0064, det_level3 = 16'h07d0;
  logic [`FREQ_W-1:0]   det_width3 = 16'h0064, det_level4 = 16'h01f4, det_level5 = 16'h01f4;
  logic [`FREQ_W-1:0]   det_level6 = 16'h05dc, brake_release_level = 16'h0320;
  logic [`FREQ_W-1:0]   brake_set_level = 16'h0258;
  logic [`CUR_W-1:0]    out_cur = 14'h0190, cur_agree_level = 14'h01f4;
  logic [`CUR_W-1:0]    cur_agree_level2 = 14'h0258, low_cur_level = 14'h012c;
  logic [`DLY_W-1:0]    cur_agree_delay = 16'h000a, low_cur_delay = 16'h0014;
  wire                  relay_one, relay_two, photo_out;
  wire  [2:0]           sensed;
  int                   num_errors = 0, checked = 0;
  // {freq, accel decel active, expected relay_one relay_two photo}
  logic [21:0]          rows [14] = '{
    {16'h0190, 3'b001, 3'b110}, {16'h041a, 3'b001, 3'b110}, {16'h04b0, 3'b001, 3'b010},
    {16'h0898, 3'b001, 3'b001}, {16'h0708, 3'b001, 3'b001}, {16'h0578, 3'b001, 3'b010},
    {16'h02bc, 3'b001, 3'b010}, {16'h0190, 3'b001, 3'b110}, {16'h0384, 3'b101, 3'b011},
    {16'h04b0, 3'b101, 3'b111}, {16'h02bc, 3'b011, 3'b111}, {16'h0226, 3'b011, 3'b101},
    {16'h0190, 3'b011, 3'b001}, {16'h0190, 3'b000, 3'b000}};

  always #50 clk = ~clk;

  // a 1 kHz setting gives a 10-cycle tick, so the 100 ms release is 100 cycles
  output_condition_detector #(.CLK_HZ(1000)) DUT (.*);
  load_model partner (.clk(clk), .drive({relay_one, relay_two, photo_out}), .closed(sensed));

  task close_out;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // wait n cycles, compare half a cycle after the last but one edge,
  // then end on the edge at which the next inputs are driven
  task chk(input int n, input string nm, input logic [2:0] e);
    repeat (n - 1) @(posedge clk);
    @(negedge clk);
    checked += 2;
    if ({relay_one, relay_two, photo_out} !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", nm, e, {relay_one, relay_two, photo_out});
    end
    // the load sees each drive one cycle late, so it has settled by now too
    if (sensed !== e) begin
      num_errors++;
      $display("MISMATCH %s load expected %b seen %b", nm, e, sensed);
    end
    @(posedge clk);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      @(posedge clk);
      if (i == 8) begin
        fsel_relay_one <= `FC_CRANE;
        fsel_relay_two <= `FC_BRAKE;
        fsel_photo     <= `FC_FREQ_OUT;
      end
      out_freq <= rows[i][21:6];
      {accel, decel, freq_active} <= rows[i][5:3];
      chk(5, "freq row", rows[i][2:0]);
    end
    @(posedge clk);
    {fsel_relay_one, fsel_relay_two, fsel_photo} <= 18'h00000;
    {relay_polarity, photo_polarity} <= 3'b111;
    chk(4, "polarity all", 3'b111);
    relay_polarity <= 2'b01;
    photo_polarity <= 1'b0;
    chk(4, "polarity one", 3'b100);
    fsel_relay_one <= `FC_CUR_AGREE;
    fsel_relay_two <= `FC_LOW_CUR;
    relay_polarity <= 2'b00;
    out_cur <= 14'h0226;
    chk(50, "agree delayed", 3'b000);
    chk(100, "agree on", 3'b100);
    out_cur <= 14'h0208;
    chk(150, "agree level two clamp", 3'b100);
    out_cur <= 14'h0190;
    chk(50, "agree release early", 3'b100);
    chk(100, "agree released", 3'b000);
    out_cur <= 14'h00c8;
    chk(100, "low current early", 3'b000);
    chk(150, "low current on", 3'b010);
    out_cur <= 14'h0190;
    chk(50, "low release early", 3'b010);
    chk(100, "low released", 3'b000);
    low_cur_level <= `LOW_CUR_OFF;
    out_cur <= 14'h0000;
    chk(300, "low disabled", 3'b000);
    // out-of-range level and width clamp to a 599.10 Hz threshold
    fsel_photo <= `FC_FDET5;
    det_level3 <= 16'hffff;
    det_width3 <= 16'h0000;
    out_freq   <= 16'hea07;
    chk(5, "level and width clamp", 3'b001);
    close_out;
  end

  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    $display("MISMATCH watchdog expected done seen hang");
    close_out;
  end
endmodule // testbench
